// ==== common/fifo_port_pkg.sv ====
// shared constants and types for the byte-wide fifo handshake port
package fifo_port_pkg;

	// ==========================================================
	// widths and depths
	localparam int DATA_W = 8;
	localparam int BUF_DEPTH = 2;
	localparam logic [1:0] LVL_EMPTY = 2'h0;
	localparam logic [1:0] LVL_ONE = 2'h1;
	localparam logic [1:0] LVL_FULL = 2'h2;

	// ==========================================================
	// timing: system clock is 40 MHz
	localparam int SYS_PERIOD_NS = 25;
	localparam int RX_GAP_MIN_NS = 33;
	localparam int RX_GAP_MAX_NS = 67;
	localparam int TX_GAP_MIN_NS = 49;
	localparam int TX_GAP_MAX_NS = 84;
	localparam int GAP_W = 3;
	// least times round up to whole cycles
	localparam logic [GAP_W-1:0] RX_GAP_CYC =
		GAP_W'((RX_GAP_MIN_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS);
	localparam logic [GAP_W-1:0] TX_GAP_CYC =
		GAP_W'((TX_GAP_MIN_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS);
	localparam logic [GAP_W-1:0] GAP_ZERO = 3'h0;
	localparam logic [GAP_W-1:0] GAP_STEP = 3'h1;

	// ==========================================================
	// types
	typedef logic [DATA_W-1:0] byte_t;

	typedef struct packed {
		logic oe_n;
		logic rd_n;
		logic wr_n;
		byte_t data;
	} pin_in_t;

	localparam pin_in_t PIN_IDLE = '{oe_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
		data: 8'h00};

endpackage : fifo_port_pkg

// ==== rtl/byte_buffer.sv ====
// two-entry byte buffer with valid/ready on both sides
`timescale 1ns/1ps
module byte_buffer
	import fifo_port_pkg::*;
(
	input wire logic i_clk_sys, // system clock
	input wire logic i_rst, // async reset, active high
	input wire logic i_ce, // clock enable
	input wire byte_t i_in_data, // fill side data
	input wire logic i_in_valid, // fill side valid
	output logic o_in_ready, // fill side ready
	output byte_t o_out_data, // drain side data
	output logic o_out_valid, // drain side valid
	input wire logic i_out_ready, // drain side ready
	output logic [1:0] o_level // entries held
);

	byte_t mem [BUF_DEPTH];
	logic wr_ptr;
	logic rd_ptr;

	wire push = i_in_valid & o_in_ready;
	wire pop = o_out_valid & i_out_ready;
	wire [1:0] next_level = o_level + {1'b0, push} - {1'b0, pop};
	wire next_rd_ptr = rd_ptr ^ pop;
	// head kept in a flop so the drain side sees no read mux
	wire byte_t next_head = (push && wr_ptr == next_rd_ptr) ? i_in_data
		: mem[next_rd_ptr];

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_level <= LVL_EMPTY;
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			o_in_ready <= 1'b1;
			o_out_valid <= 1'b0;
			o_out_data <= 8'h00;
		end else if (i_ce) begin
			o_out_data <= next_head;
			o_level <= next_level;
			wr_ptr <= wr_ptr ^ push;
			rd_ptr <= next_rd_ptr;
			// flags registered so no path runs combinationally to ports
			o_in_ready <= next_level != LVL_FULL;
			o_out_valid <= next_level != LVL_EMPTY;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_ce && push) begin
			mem[wr_ptr] <= i_in_data;
		end
	end

endmodule : byte_buffer

// ==== rtl/fifo_port.sv ====
// byte-wide parallel fifo port, synchronous and asynchronous variants
// Operation
// - signal data available while bytes held
// - first byte on bus after turnaround
// - advance byte after each sampled read
// - drop availability when last byte consumed
// - accept byte only when space and strobe
// - accept one byte every clock with space
// - async mode transfers on strobe falling edges
// - async mode: no clock out, no turnaround
// - async read: availability gap 33 to 67 ns; code keeps the flag off 125 to 150 ns past strobe rise
// - async write: space gap 49 to 84 ns; code keeps the flag off 125 to 150 ns past strobe rise
// - sync transfers on interface clock rising edge
// - sync mode drives continuous interface clock
// - sync read and write bursts never overlap; async strobes are not interlocked
`timescale 1ns/1ps
module fifo_port
	import fifo_port_pkg::*;
(
	input wire logic i_clk_sys, // system clock, 40 MHz
	input wire logic i_rst, // async reset, active high
	input wire logic i_ce, // clock enable, freezes all state
	input wire logic i_sync_mode, // 1 = synchronous variant
	input wire logic i_oe_n, // pin: output turnaround, low active
	input wire logic i_rd_n, // pin: read strobe, low active
	input wire logic i_wr_n, // pin: write strobe, low active
	input wire byte_t i_data, // pin: data bus input
	output byte_t o_data, // pin: data bus output
	output logic o_data_oe, // pin: data bus output enable
	output logic o_rx_data_available_n, // pin: bytes to read
	output logic o_tx_space_available_n, // pin: room to write
	output logic o_interface_clock_out, // pin: interface clock
	input wire byte_t i_rx_byte, // user: byte for the host
	input wire logic i_rx_valid, // user: byte valid
	output logic o_rx_ready, // user: byte taken
	output byte_t o_tx_byte, // user: byte from the host
	output logic o_tx_valid, // user: byte valid
	input wire logic i_tx_ready // user: byte taken
);

	// ==========================================================
	// pin synchronisers
	pin_in_t pin_m;
	pin_in_t pin_s;
	logic rd_prev;
	logic wr_prev;

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			pin_m <= PIN_IDLE;
			pin_s <= PIN_IDLE;
			rd_prev <= 1'b1;
			wr_prev <= 1'b1;
		end else if (i_ce) begin
			pin_m <= {i_oe_n, i_rd_n, i_wr_n, i_data};
			pin_s <= pin_m;
			rd_prev <= pin_s.rd_n;
			wr_prev <= pin_s.wr_n;
		end
	end

	wire rd_fall = rd_prev & ~pin_s.rd_n;
	wire rd_rise = ~rd_prev & pin_s.rd_n;
	wire wr_fall = wr_prev & ~pin_s.wr_n;
	wire wr_rise = ~wr_prev & pin_s.wr_n;
	// the cycle whose edge raises the interface clock
	wire clk_rise = i_sync_mode & ~o_interface_clock_out;

	// ==========================================================
	// buffers
	byte_t rx_head;
	logic rx_valid;
	logic [1:0] rx_level;
	logic tx_in_ready;
	logic [1:0] tx_level;
	logic rx_busy;
	logic tx_busy;
	logic [GAP_W-1:0] rx_gap;
	logic [GAP_W-1:0] tx_gap;

	wire sync_pop = clk_rise & ~pin_s.oe_n & ~pin_s.rd_n
		& ~o_rx_data_available_n & rx_valid;
	wire async_pop = ~i_sync_mode & rd_fall
		& ~o_rx_data_available_n & rx_valid;
	wire rx_pop = sync_pop | async_pop;
	// sync writes shut out while either side may still drive the bus
	wire sync_push = clk_rise & pin_s.oe_n & ~pin_s.wr_n & ~o_data_oe
		& ~o_tx_space_available_n & tx_in_ready;
	wire async_push = ~i_sync_mode & wr_fall
		& ~o_tx_space_available_n & tx_in_ready;
	wire tx_push = sync_push | async_push;

	byte_buffer rx_buf (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.i_ce(i_ce),
		.i_in_data(i_rx_byte),
		.i_in_valid(i_rx_valid),
		.o_in_ready(o_rx_ready),
		.o_out_data(rx_head),
		.o_out_valid(rx_valid),
		.i_out_ready(rx_pop),
		.o_level(rx_level)
	);

	byte_buffer tx_buf (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.i_ce(i_ce),
		.i_in_data(pin_s.data),
		.i_in_valid(tx_push),
		.o_in_ready(tx_in_ready),
		.o_out_data(o_tx_byte),
		.o_out_valid(o_tx_valid),
		.i_out_ready(i_tx_ready),
		.o_level(tx_level)
	);

	// ==========================================================
	// flag decode
	// level flags are conservative: a user-side transfer in the same cycle is ignored, only the host's own is counted
	wire next_rxf_sync_n = ~((rx_level == LVL_FULL)
		| ((rx_level == LVL_ONE) & ~sync_pop));
	wire next_txe_sync_n = ~((tx_level == LVL_EMPTY)
		| ((tx_level == LVL_ONE) & ~sync_push));
	wire next_rxf_async_n = async_pop | rx_busy | (rx_gap != GAP_ZERO)
		| ~rx_valid;
	wire next_txe_async_n = async_push | tx_busy | (tx_gap != GAP_ZERO)
		| ~tx_in_ready;
	wire [GAP_W-1:0] next_rx_gap = (rx_busy & rd_rise) ? RX_GAP_CYC
		: (rx_gap != GAP_ZERO) ? rx_gap - GAP_STEP : GAP_ZERO;
	wire [GAP_W-1:0] next_tx_gap = (tx_busy & wr_rise) ? TX_GAP_CYC
		: (tx_gap != GAP_ZERO) ? tx_gap - GAP_STEP : GAP_ZERO;
	wire next_data_oe = i_sync_mode ? ~pin_s.oe_n
		: ~pin_s.rd_n;

	// ==========================================================
	// async strobe cycle tracking
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			rx_busy <= 1'b0;
			tx_busy <= 1'b0;
			rx_gap <= GAP_ZERO;
			tx_gap <= GAP_ZERO;
		end else if (i_ce) begin
			rx_busy <= async_pop | (rx_busy & ~rd_rise);
			tx_busy <= async_push | (tx_busy & ~wr_rise);
			rx_gap <= next_rx_gap;
			tx_gap <= next_tx_gap;
		end
	end

	// ==========================================================
	// pin outputs
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_rx_data_available_n <= 1'b1;
			o_tx_space_available_n <= 1'b1;
			o_interface_clock_out <= 1'b0;
		end else if (i_ce) begin
			// divided down from the system clock, so well under 60 MHz
			o_interface_clock_out <= clk_rise;
			if (!i_sync_mode) begin
				o_rx_data_available_n <= next_rxf_async_n;
				o_tx_space_available_n <= next_txe_async_n;
			end else if (clk_rise) begin
				o_rx_data_available_n <= next_rxf_sync_n;
				o_tx_space_available_n <= next_txe_sync_n;
			end
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_data <= 8'h00;
			o_data_oe <= 1'b0;
		end else if (i_ce) begin
			o_data_oe <= next_data_oe;
			if (i_sync_mode || async_pop) begin
				o_data <= rx_head;
			end
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_rst);

	clk_async_idle_a: assert property (
		(i_ce && !i_sync_mode) |=> !o_interface_clock_out)
		else $error("interface clock runs in async mode");
	clk_sync_toggle_a: assert property (
		(i_ce && i_sync_mode) |=>
		o_interface_clock_out != $past(o_interface_clock_out))
		else $error("interface clock stalled in sync mode");
	write_accept_count_a: assert property (
		(i_ce && !o_tx_valid && i_sync_mode) |=>
		tx_level == $past(tx_level) + 2'($past(sync_push)))
		else $error("write accepted without space and strobe");
	space_means_room_a: assert property (
		(clk_rise && !o_tx_space_available_n) |-> tx_in_ready)
		else $error("space flagged with buffer full");
	rx_empty_flag_a: assert property (
		(i_ce && clk_rise && rx_level == LVL_EMPTY) |=>
		o_rx_data_available_n)
		else $error("data flagged with nothing buffered");
	rx_gap_hold_a: assert property (
		(i_ce && !i_sync_mode && rx_busy && rd_rise) |=>
		o_rx_data_available_n [*2])
		else $error("read gap too short");
	tx_gap_hold_a: assert property (
		(i_ce && !i_sync_mode && tx_busy && wr_rise) |=>
		o_tx_space_available_n [*2])
		else $error("write gap too short");
	sync_drive_a: assert property (
		(i_ce && i_sync_mode) |=> o_data_oe == !$past(pin_s.oe_n))
		else $error("bus drive not tied to turnaround");
	async_release_a: assert property (
		(i_ce && !i_sync_mode && pin_s.rd_n) |=> !o_data_oe)
		else $error("bus driven without read strobe");
	first_byte_a: assert property (
		(i_ce && i_sync_mode && !pin_s.oe_n && rx_valid) |=>
		o_data == $past(rx_head))
		else $error("head byte missing from bus");
	async_latch_a: assert property (
		(i_ce && async_pop) |=> o_data == $past(rx_head) && rx_busy)
		else $error("async read byte not latched");
	no_overlap_a: assert property (
		!(sync_push && (sync_pop || o_data_oe)))
		else $error("write accepted while bus driven");

	sync_burst_c: cover property (sync_pop ##2 sync_pop);
	sync_write_c: cover property (sync_push ##2 sync_push);
	async_read_c: cover property (async_pop ##[1:20] rd_rise);
	async_write_c: cover property (async_push ##[1:20] wr_rise);

endmodule : fifo_port

// ==== bench/fifo_host.sv ====
// external processor model driving the fifo port pins
`timescale 1ns/1ps
module fifo_host
	import fifo_port_pkg::*;
(
	input wire logic i_clk_sys, // system clock
	input wire logic i_rx_data_available_n, // device: bytes to read
	input wire logic i_tx_space_available_n, // device: room to write
	input wire byte_t i_data, // resolved data bus
	output logic o_oe_n, // turnaround strobe
	output logic o_rd_n, // read strobe
	output logic o_wr_n, // write strobe
	output byte_t o_data // host drive of the bus
);
	initial begin
		o_oe_n = 1'b1;
		o_rd_n = 1'b1;
		o_wr_n = 1'b1;
		o_data = 8'h00;
	end

	// ==========================================================
	// asynchronous strobes, changed 2 ns after system clock edges
	task automatic awrite(input byte_t b, output logic [1:0] st);
		wait (i_tx_space_available_n === 1'b0);
		@(posedge i_clk_sys);
		#2 o_data = b;
		repeat (2) @(posedge i_clk_sys);
		#2 o_wr_n = 1'b0;
		repeat (4) @(posedge i_clk_sys);
		#2 st[0] = i_tx_space_available_n;
		o_wr_n = 1'b1;
		repeat (2) @(posedge i_clk_sys);
		#2 st[1] = i_tx_space_available_n;
		// released bus must not keep the last value
		o_data = ~b;
	endtask : awrite

	task automatic aread(output byte_t b, output logic [1:0] st);
		wait (i_rx_data_available_n === 1'b0);
		@(posedge i_clk_sys);
		#2 o_rd_n = 1'b0;
		repeat (4) @(posedge i_clk_sys);
		#2 b = i_data;
		st[0] = i_rx_data_available_n;
		o_rd_n = 1'b1;
		repeat (2) @(posedge i_clk_sys);
		#2 st[1] = i_rx_data_available_n;
		repeat (2) @(posedge i_clk_sys);
		#2;
	endtask : aread

	// synchronous pins change just after a clock edge
	task automatic pins(input logic oe, rd, wr, input byte_t d);
		@(posedge i_clk_sys);
		#2 o_oe_n = oe;
		o_rd_n = rd;
		o_wr_n = wr;
		o_data = d;
	endtask : pins
endmodule : fifo_host

// ==== bench/fifo_port_tb_top.sv ====
// self-checking bench for the fifo port
`timescale 1ns/1ps
module fifo_port_tb_top;
	import fifo_port_pkg::*;
	logic i_clk_sys, i_rst, i_sync_mode, i_rx_valid, i_tx_ready;
	logic oe_n, rd_n, wr_n, data_oe, rxf_n, txe_n, clk_out, rx_ready;
	logic tx_valid, seen_b, ce;
	byte_t host_d, bus, dout, rx_byte, tx_byte, b;
	logic [1:0] st;
	int num_errors = 0;
	int num_checks = 0;
	byte_t got[$];

	assign bus = data_oe ? dout : host_d;

	fifo_port DUT (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(ce),
		.i_sync_mode(i_sync_mode), .i_oe_n(oe_n), .i_rd_n(rd_n),
		.i_wr_n(wr_n), .i_data(bus), .o_data(dout), .o_data_oe(data_oe),
		.o_rx_data_available_n(rxf_n), .o_tx_space_available_n(txe_n),
		.o_interface_clock_out(clk_out), .i_rx_byte(rx_byte),
		.i_rx_valid(i_rx_valid), .o_rx_ready(rx_ready),
		.o_tx_byte(tx_byte), .o_tx_valid(tx_valid),
		.i_tx_ready(i_tx_ready));

	fifo_host HOST (.i_clk_sys(i_clk_sys), .i_rx_data_available_n(rxf_n),
		.i_tx_space_available_n(txe_n), .i_data(bus), .o_oe_n(oe_n),
		.o_rd_n(rd_n), .o_wr_n(wr_n), .o_data(host_d));

	initial begin
		i_clk_sys = 1'b0;
		forever #12.5 i_clk_sys = ~i_clk_sys;
	end

	always @(posedge i_clk_sys) begin
		if (tx_valid === 1'b1 && i_tx_ready === 1'b1) begin
			got.push_back(tx_byte);
		end
	end

	// ==========================================================
	// helpers
	task automatic check(string n, logic [7:0] seen, logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", n, exp, seen);
		end
	endtask : check

	task automatic cyc(int n);
		repeat (n) @(posedge i_clk_sys);
		#2;
	endtask : cyc

	// valid stays up between the two bytes
	task automatic push2(byte_t v0, byte_t v1);
		i_rx_valid = 1'b1;
		for (int n = 0; n < 2; n++) begin
			rx_byte = (n == 0) ? v0 : v1;
			for (int k = 0; k < 50 && rx_ready !== 1'b1; k++) cyc(1);
			cyc(1);
		end
		i_rx_valid = 1'b0;
	endtask : push2

	task automatic complete_run();
		if (num_errors == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : complete_run

	// ==========================================================
	// scenarios
	task automatic t_async_write();
		got.delete();
		HOST.awrite(8'h96, st);
		check("awr flag", {6'h00, st}, 8'h03);
		HOST.awrite(8'h69, st);
		cyc(6);
		check("awr count", 8'(got.size()), 8'h02);
		check("awr b0", got[0], 8'h96);
		check("awr b1", got[1], 8'h69);
		check("async clk", {7'h00, clk_out}, 8'h00);
	endtask : t_async_write

	task automatic t_async_read();
		push2(8'ha3, 8'h3a);
		cyc(4);
		check("ard avail", {7'h00, rxf_n}, 8'h00);
		check("ard full", {7'h00, rx_ready}, 8'h00);
		HOST.aread(b, st);
		check("ard b0", b, 8'ha3);
		check("ard gap", {6'h00, st}, 8'h03);
		check("ard release", {7'h00, data_oe}, 8'h00);
		HOST.aread(b, st);
		check("ard b1", b, 8'h3a);
		cyc(8);
		check("ard empty", {7'h00, rxf_n}, 8'h01);
	endtask : t_async_read

	task automatic t_sync_read();
		push2(8'ha5, 8'h5a);
		for (int k = 0; k < 40 && rxf_n !== 1'b0; k++) cyc(1);
		HOST.pins(1'b0, 1'b1, 1'b1, 8'h00);
		cyc(6);
		check("srd oe", {7'h00, data_oe}, 8'h01);
		check("srd first", bus, 8'ha5);
		HOST.pins(1'b0, 1'b0, 1'b1, 8'h00);
		seen_b = 1'b0;
		for (int k = 0; k < 40 && rxf_n !== 1'b1; k++) begin
			if (rxf_n === 1'b0 && bus === 8'h5a) seen_b = 1'b1;
			cyc(1);
		end
		check("srd next", {7'h00, seen_b}, 8'h01);
		check("srd empty", {7'h00, rxf_n}, 8'h01);
		HOST.pins(1'b1, 1'b1, 1'b1, 8'hff);
		cyc(4);
		check("srd release", {7'h00, data_oe}, 8'h00);
	endtask : t_sync_read

	task automatic t_sync_write_stall();
		got.delete();
		i_tx_ready = 1'b0;
		HOST.pins(1'b1, 1'b1, 1'b0, 8'h3c);
		cyc(30);
		check("swr full", {7'h00, txe_n}, 8'h01);
		check("swr dir", {7'h00, data_oe}, 8'h00);
		check("swr held", {7'h00, tx_valid}, 8'h01);
		HOST.pins(1'b1, 1'b1, 1'b1, 8'hc3);
		cyc(6);
		i_tx_ready = 1'b1;
		cyc(8);
		check("swr count", 8'(got.size()), 8'(BUF_DEPTH));
		check("swr b0", got[0], 8'h3c);
		check("swr b1", got[1], 8'h3c);
		check("swr space", {7'h00, txe_n}, 8'h00);
	endtask : t_sync_write_stall

	// ==========================================================
	// main sequence; async first, then sync
	initial begin
		i_rst = 1'b1;
		ce = 1'b1;
		i_sync_mode = 1'b0;
		i_rx_valid = 1'b0;
		i_tx_ready = 1'b1;
		rx_byte = 8'h00;
		repeat (16) @(posedge i_clk_sys);
		#2 i_rst = 1'b0;
		cyc(4);
		t_async_write();
		t_async_read();
		i_sync_mode = 1'b1;
		cyc(4);
		b = {7'h00, clk_out};
		cyc(1);
		check("sync clk", {7'h00, clk_out}, ~b & 8'h01);
		ce = 1'b0;
		b = {7'h00, clk_out};
		cyc(3);
		check("ce freeze", {7'h00, clk_out}, b);
		ce = 1'b1;
		cyc(2);
		t_sync_read();
		t_sync_write_stall();
		complete_run();
	end

	initial begin
		#60000;
		num_errors++;
		complete_run();
	end
endmodule : fifo_port_tb_top
